/* rtl/clk_cfg_pkg.sv */
// package for the pll supervision and chip configuration block
// assumes one 125 MHz system clock and synchronous pin inputs
package clk_cfg_pkg;

	localparam int unsigned CLK_MHZ        = 125;
	localparam int unsigned MUX_GAP_NS     = 40;
	localparam int unsigned MUX_GAP_CYC    =
		(MUX_GAP_NS * CLK_MHZ + 999) / 1000;

	localparam int unsigned GPIO_COUNT     = 30;
	localparam logic [4:0]  GINT_SEL_ZERO  = 5'h1e;
	localparam logic [4:0]  GINT_SEL_ONE   = 5'h1f;
	localparam logic [4:0]  GINT_SEL_RESET = 5'h1e;

	localparam logic [1:0]  PORT2_UART     = 2'h0;
	localparam logic [1:0]  PORT2_RSVD     = 2'h1;
	localparam logic [1:0]  PORT2_I2C_SLV  = 2'h2;
	localparam logic [1:0]  PORT2_I2C_MST  = 2'h3;
	localparam int unsigned LOCKLOSS_MASK_BIT = 31;

	localparam int unsigned CNT_W = 16;

	typedef enum logic [1:0] {
		SRC_REFERENCE,
		SRC_SYNTH,
		SRC_ALTERNATE
	} clk_src_t;

	typedef enum logic [1:0] {
		MUX_RUN,
		MUX_GAP
	} mux_state_t;

	typedef struct packed {
		logic       stage_reset_bit;
		logic       stage_bypass_bit;
		logic [3:0] loop_filter_range;
		logic [5:0] stage_input_divider;
		logic [7:0] stage_multiply_ratio;
		logic [5:0] stage_output_divider;
	} stage_cfg_t;

	typedef struct packed {
		logic             lockloss_detect_enable;
		logic [1:0]       lockloss_detect_mode;
		logic [CNT_W-1:0] ratio_min_threshold;
		logic [CNT_W-1:0] ratio_max_threshold;
		logic [CNT_W-1:0] underflow_limit;
		logic [CNT_W-1:0] overflow_limit;
		logic [CNT_W-1:0] window_len;
	} lockdet_cfg_t;

	typedef struct packed {
		logic pll_raw_lock;
		logic lockloss_flag;
		logic unlock_ind;
		logic override_flag;
	} status_t;

	typedef struct packed {
		logic uart_en;
		logic i2c_slave_en;
		logic i2c_master_en;
		logic spi_en;
		logic audio3_en;
	} port_route_t;

endpackage : clk_cfg_pkg

/* rtl/pll_lock_clock_config.sv */
// pll supervision, clock source sequencing, port routing, gpio interrupts
// assumes synchronous inputs on mclk_i; config bits arrive as plain ports
//
// What this block does
// - each stage has own reset and bypass
// - filter range follows divided reference frequency
// - each stage: input divider, ratio, output divider
// - raw lock visible in status
// - detector enabled by bit, shaped by mode
// - count ratio below min or above max
// - lockloss when exception count exceeds limit
// - lockloss flag and unlock bit in status
// - warm reset on lockloss is maskable
// - lockloss reset forces reference, sets override
// - override refuses other sources until cleared
// - field access types: ro, wo, w1c, wc, rc
// - configuration fields arrive as ports, no 32-bit register slave
// - per-port selects route shared pins
// - two selected gpios become direct interrupts
// - standby and two interrupts debounced separately
// - writing one to sleep bit starts sleep
// - mask bit 31: zero resets, one suppresses
// - source switching is glitch free
// - port2 select: uart, rsvd, i2c slave, master
// - selector codes: pins, 1e zero, 1f one
`timescale 1ns/1ps
`default_nettype none

module pll_lock_clock_config #(
	parameter int unsigned DB_W = 12
) (
	input  wire logic                      mclk_i,
	input  wire logic                      rst_b_i,
	input  wire clk_cfg_pkg::stage_cfg_t   stage1_cfg_i,
	input  wire clk_cfg_pkg::stage_cfg_t   stage2_cfg_i,
	output var clk_cfg_pkg::stage_cfg_t    stage1_cfg_o,
	output var clk_cfg_pkg::stage_cfg_t    stage2_cfg_o,
	input  wire logic                      pll_raw_lock_i,
	input  wire logic                      ref_tick_i,
	input  wire logic                      synth_tick_i,
	input  wire clk_cfg_pkg::lockdet_cfg_t lockdet_cfg_i,
	input  wire logic [31:0]               general_control_i,
	input  wire logic                      lockloss_clr_i,
	input  wire logic                      override_clr_i,
	input  wire logic                      status_rd_i,
	output var clk_cfg_pkg::status_t       general_status_o,
	output logic                           unlock_seen_o,
	output logic                           warm_reset_o,
	input  wire clk_cfg_pkg::clk_src_t     clk_sel_req_i,
	output var clk_cfg_pkg::clk_src_t      clk_sel_o,
	output logic [2:0]                     clk_gate_en_o,
	input  wire logic                      port1_sel_i,
	output var clk_cfg_pkg::port_route_t   port_route_o,
	input  wire logic [clk_cfg_pkg::GPIO_COUNT-1:0] gpio_i,
	input  wire logic                      standby_i,
	input  wire logic [DB_W-1:0]           standby_debounce_reg_i,
	input  wire logic [DB_W-1:0]           gpio_int1_debounce_reg_i,
	input  wire logic [DB_W-1:0]           gpio_int2_debounce_reg_i,
	output logic                           standby_irq_o,
	output logic                           gpio_int1_o,
	output logic                           gpio_int2_o,
	input  wire logic                      wakeup_ctrl_wr_i,
	input  wire logic                      sleep_enable_bit_i,
	output logic                           sleep_start_o
);

	if (DB_W < 1 || DB_W > 24) begin : g_bad_db_w
		$error("DB_W out of range");
	end

	localparam int unsigned CW = clk_cfg_pkg::CNT_W;

	// control word fields arrive as port bits of the 32-bit word
	logic [4:0] gint1_sel;
	logic [4:0] gint2_sel;
	logic [1:0] port2_sel;
	logic       lockloss_reset_mask;
	assign gint1_sel           = general_control_i[12:8];
	assign gint2_sel           = general_control_i[20:16];
	assign port2_sel           = general_control_i[7:6];
	assign lockloss_reset_mask =
		general_control_i[clk_cfg_pkg::LOCKLOSS_MASK_BIT];

	// stage configuration, held per stage
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			stage1_cfg_o <= '{1'b1, 1'b1, 4'h0, 6'h00, 8'h00, 6'h00};
			stage2_cfg_o <= '{1'b1, 1'b1, 4'h0, 6'h00, 8'h00, 6'h00};
		end else begin
			stage1_cfg_o <= stage1_cfg_i;
			stage2_cfg_o <= stage2_cfg_i;
		end
	end

	// ratio window: count synth ticks across window_len+1 ref ticks
	logic [CW-1:0] ref_cnt_q;
	logic [CW-1:0] synth_cnt_q;
	logic [CW-1:0] under_cnt_q;
	logic [CW-1:0] over_cnt_q;
	logic          det_on;
	logic          win_end;
	logic          below;
	logic          above;
	logic          lockloss_cond;

	assign det_on  = lockdet_cfg_i.lockloss_detect_enable;
	assign win_end = det_on && ref_tick_i &&
		(ref_cnt_q >= lockdet_cfg_i.window_len);
	assign below   = lockdet_cfg_i.lockloss_detect_mode[0] &&
		(synth_cnt_q < lockdet_cfg_i.ratio_min_threshold);
	assign above   = lockdet_cfg_i.lockloss_detect_mode[1] &&
		(synth_cnt_q > lockdet_cfg_i.ratio_max_threshold);

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ref_cnt_q   <= '0;
			synth_cnt_q <= '0;
		end else if (!det_on || win_end) begin
			ref_cnt_q   <= '0;
			synth_cnt_q <= '0;
		end else begin
			if (ref_tick_i) begin
				ref_cnt_q <= ref_cnt_q + CW'(1);
			end
			if (synth_tick_i && synth_cnt_q != '1) begin
				synth_cnt_q <= synth_cnt_q + CW'(1);
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			under_cnt_q <= '0;
			over_cnt_q  <= '0;
		end else if (!det_on) begin
			under_cnt_q <= '0;
			over_cnt_q  <= '0;
		end else if (win_end) begin
			if (below && under_cnt_q != '1) begin
				under_cnt_q <= under_cnt_q + CW'(1);
			end
			if (above && over_cnt_q != '1) begin
				over_cnt_q <= over_cnt_q + CW'(1);
			end
		end
	end

	assign lockloss_cond = det_on &&
		((under_cnt_q > lockdet_cfg_i.underflow_limit) ||
		 (over_cnt_q > lockdet_cfg_i.overflow_limit));

	// status flags: hardware set wins over software clear
	logic lockloss_q;
	logic lockloss_rise;
	logic override_q;
	logic cond_q;
	assign lockloss_rise = lockloss_cond && !cond_q;

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cond_q <= 1'b0;
		end else begin
			cond_q <= lockloss_cond;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lockloss_q <= 1'b0;
		end else if (lockloss_cond) begin
			lockloss_q <= 1'b1;
		end else if (lockloss_clr_i) begin
			lockloss_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			unlock_seen_o <= 1'b0;
		end else if (lockloss_cond) begin
			unlock_seen_o <= 1'b1;
		end else if (status_rd_i) begin
			unlock_seen_o <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			warm_reset_o <= 1'b0;
		end else begin
			warm_reset_o <= lockloss_rise && !lockloss_reset_mask;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			override_q <= 1'b0;
		end else if (lockloss_rise && !lockloss_reset_mask) begin
			override_q <= 1'b1;
		end else if (override_clr_i) begin
			override_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			general_status_o <= '0;
		end else begin
			general_status_o.pll_raw_lock  <= pll_raw_lock_i;
			general_status_o.lockloss_flag <= lockloss_q;
			general_status_o.unlock_ind    <= lockloss_cond;
			general_status_o.override_flag <= override_q;
		end
	end

	// source sequencer: close old gate, wait gap, open new gate
	localparam int unsigned GAP_W = $clog2(clk_cfg_pkg::MUX_GAP_CYC + 1);
	localparam logic [GAP_W-1:0] GAP_LAST =
		GAP_W'(clk_cfg_pkg::MUX_GAP_CYC - 1);

	clk_cfg_pkg::mux_state_t mux_state_q;
	clk_cfg_pkg::clk_src_t   want;
	logic [GAP_W-1:0]        gap_cnt_q;
	logic                    forced;

	assign forced = override_q || (lockloss_rise && !lockloss_reset_mask);

	always_comb begin
		want = clk_sel_req_i;
		if (forced) begin
			want = clk_cfg_pkg::SRC_REFERENCE;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mux_state_q <= clk_cfg_pkg::MUX_RUN;
			clk_sel_o   <= clk_cfg_pkg::SRC_REFERENCE;
			gap_cnt_q   <= '0;
		end else begin
			unique case (mux_state_q)
				clk_cfg_pkg::MUX_RUN: begin
					if (want != clk_sel_o) begin
						clk_sel_o   <= want;
						gap_cnt_q   <= '0;
						mux_state_q <= clk_cfg_pkg::MUX_GAP;
					end
				end
				clk_cfg_pkg::MUX_GAP: begin
					if (gap_cnt_q == GAP_LAST) begin
						mux_state_q <= clk_cfg_pkg::MUX_RUN;
					end else begin
						gap_cnt_q <= gap_cnt_q + GAP_W'(1);
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			clk_gate_en_o <= 3'h1;
		end else if (mux_state_q == clk_cfg_pkg::MUX_RUN &&
			want == clk_sel_o) begin
			clk_gate_en_o <= 3'h1 << clk_sel_o;
		end else begin
			clk_gate_en_o <= 3'h0;
		end
	end

	// shared pin routing
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			port_route_o <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
		end else begin
			port_route_o.uart_en <= port2_sel == clk_cfg_pkg::PORT2_UART;
			port_route_o.i2c_slave_en <=
				port2_sel == clk_cfg_pkg::PORT2_I2C_SLV;
			port_route_o.i2c_master_en <=
				port2_sel == clk_cfg_pkg::PORT2_I2C_MST;
			port_route_o.spi_en    <= !port1_sel_i;
			port_route_o.audio3_en <= port1_sel_i;
		end
	end

	// direct interrupt selection
	function automatic logic pick(input logic [4:0] sel,
		input logic [clk_cfg_pkg::GPIO_COUNT-1:0] pins);
		logic v;
		v = 1'b0;
		if (sel == clk_cfg_pkg::GINT_SEL_ONE) begin
			v = 1'b1;
		end else if (sel != clk_cfg_pkg::GINT_SEL_ZERO) begin
			v = pins[sel];
		end
		return v;
	endfunction : pick

	logic [2:0]      db_in;
	logic [2:0]      db_out;
	logic [DB_W-1:0] db_len [3];
	assign db_in[0]  = standby_i;
	assign db_in[1]  = pick(gint1_sel, gpio_i);
	assign db_in[2]  = pick(gint2_sel, gpio_i);
	assign db_len[0] = standby_debounce_reg_i;
	assign db_len[1] = gpio_int1_debounce_reg_i;
	assign db_len[2] = gpio_int2_debounce_reg_i;

	// debounce: output follows input once it differs for db_len+1 cycles
	for (genvar g = 0; g < 3; g++) begin : g_db
		logic [DB_W-1:0] cnt_q;
		logic            out_q;
		always_ff @(posedge mclk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				cnt_q <= '0;
				out_q <= 1'b0;
			end else if (db_in[g] == out_q) begin
				cnt_q <= '0;
			end else if (cnt_q >= db_len[g]) begin
				out_q <= db_in[g];
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + DB_W'(1);
			end
		end
		assign db_out[g] = out_q;
	end

	assign standby_irq_o = db_out[0];
	assign gpio_int1_o   = db_out[1];
	assign gpio_int2_o   = db_out[2];

	// sleep command, write-only bit
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sleep_start_o <= 1'b0;
		end else begin
			sleep_start_o <= wakeup_ctrl_wr_i &&
				sleep_enable_bit_i;
		end
	end

endmodule : pll_lock_clock_config

`default_nettype wire

/* test/pll_far_model.sv */
// far side model: synthesiser lock level and divided clock ticks
// assumes one ref tick per four cycles, one synth tick per cycle when locked
`timescale 1ns/1ps
`default_nettype none
module pll_far_model (
	input  wire logic mclk_i,
	input  wire logic rst_b_i,
	input  wire logic locked_i,
	output logic      pll_raw_lock_o,
	output logic      ref_tick_o,
	output logic      synth_tick_o
);
	logic [1:0] div_q;
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) div_q <= 2'h0;
		else div_q <= div_q + 2'h1;
	end
	assign ref_tick_o     = (div_q == 2'h3);
	// no output ticks once lock is lost
	assign synth_tick_o   = locked_i & rst_b_i;
	assign pll_raw_lock_o = locked_i;
endmodule : pll_far_model
`default_nettype wire

/* test/pll_cfg_props.sv */
// checker for clock sequencing, lockloss reset, routing and sleep start
// assumes the ports of pll_lock_clock_config, bound below
`timescale 1ns/1ps
`default_nettype none
module pll_cfg_props (
	input wire logic                     mclk_i,
	input wire logic                     rst_b_i,
	input wire logic [31:0]              general_control_i,
	input wire logic                     wakeup_ctrl_wr_i,
	input wire logic                     sleep_enable_bit_i,
	input wire logic                     sleep_start_o,
	input wire logic                     warm_reset_o,
	input wire clk_cfg_pkg::status_t     general_status_o,
	input wire clk_cfg_pkg::clk_src_t    clk_sel_o,
	input wire logic [2:0]               clk_gate_en_o,
	input wire clk_cfg_pkg::port_route_t port_route_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_gap;
		(clk_gate_en_o == 3'h0) [*6];
	endsequence
	sequence s_gate_back;
		##[6:40] (clk_gate_en_o == (3'h1 << clk_sel_o));
	endsequence
	a_sleep_start: assert property (
		wakeup_ctrl_wr_i && sleep_enable_bit_i |=> sleep_start_o)
		else $error("sleep start missing");
	a_sleep_quiet: assert property (
		!(wakeup_ctrl_wr_i && sleep_enable_bit_i) |=> !sleep_start_o)
		else $error("sleep start without write");
	a_warm_pulse: assert property (warm_reset_o |=> !warm_reset_o)
		else $error("warm reset longer than one cycle");
	a_warm_mask: assert property (
		warm_reset_o |-> !$past(general_control_i[31]))
		else $error("warm reset while masked");
	a_force_ref: assert property (warm_reset_o |=>
		clk_sel_o == clk_cfg_pkg::SRC_REFERENCE
		&& general_status_o.override_flag)
		else $error("lockloss reset did not force reference");
	a_override_ref: assert property (
		general_status_o.override_flag
		|-> clk_sel_o == clk_cfg_pkg::SRC_REFERENCE)
		else $error("source changed under override");
	a_gap_hold: assert property ($changed(clk_sel_o) |-> s_gap)
		else $error("gate open during switch gap");
	a_gate_back: assert property (
		$changed(clk_sel_o) |-> s_gate_back)
		else $error("new gate not opened");
	a_gate_onehot: assert property ($onehot0(clk_gate_en_o))
		else $error("two gates open");
	a_port2_master: assert property (
		general_control_i[7:6] == 2'h3
		|=> port_route_o.i2c_master_en && !port_route_o.uart_en)
		else $error("port2 master route wrong");
endmodule : pll_cfg_props
bind pll_lock_clock_config pll_cfg_props props_u (.mclk_i, .rst_b_i,
	.general_control_i, .wakeup_ctrl_wr_i, .sleep_enable_bit_i,
	.sleep_start_o, .warm_reset_o, .general_status_o, .clk_sel_o,
	.clk_gate_en_o, .port_route_o);
`default_nettype wire

/* test/pll_lock_clock_config_tb.sv */
// self-checking bench for pll_lock_clock_config
// assumes pll_far_model drives lock and ticks; checker bound separately
`timescale 1ns/1ps
`default_nettype none
module pll_lock_clock_config_tb;
	logic mclk_i = 1'h0, rst_b_i = 1'h0, locked = 1'h0, raw, rt, st;
	clk_cfg_pkg::stage_cfg_t s1_i = '0, s2_i = '0, s1_o, s2_o;
	clk_cfg_pkg::lockdet_cfg_t ld = '0;
	clk_cfg_pkg::status_t st_o;
	clk_cfg_pkg::clk_src_t req = clk_cfg_pkg::SRC_REFERENCE, sel;
	clk_cfg_pkg::port_route_t route;
	logic [31:0] gc = 32'h001e_1e00;
	logic [29:0] gpio = '0;
	logic [11:0] db = 12'h002;
	logic [2:0] gate;
	logic lclr = 1'h0, oclr = 1'h0, srd = 1'h0, wr = 1'h0, slp = 1'h0;
	logic sby = 1'h0, p1 = 1'h0, sb_irq, g1, g2, useen, wrst, slps;
	int mismatches = 0, samples_checked = 0, cyc = 0, warm_cnt = 0;
	pll_far_model far_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.locked_i(locked), .pll_raw_lock_o(raw), .ref_tick_o(rt),
		.synth_tick_o(st));
	pll_lock_clock_config dut_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.stage1_cfg_i(s1_i), .stage2_cfg_i(s2_i), .stage1_cfg_o(s1_o),
		.stage2_cfg_o(s2_o), .pll_raw_lock_i(raw), .ref_tick_i(rt),
		.synth_tick_i(st), .lockdet_cfg_i(ld), .general_control_i(gc),
		.lockloss_clr_i(lclr), .override_clr_i(oclr), .status_rd_i(srd),
		.general_status_o(st_o), .unlock_seen_o(useen),
		.warm_reset_o(wrst), .clk_sel_req_i(req), .clk_sel_o(sel),
		.clk_gate_en_o(gate), .port1_sel_i(p1), .port_route_o(route),
		.gpio_i(gpio), .standby_i(sby), .standby_debounce_reg_i(db),
		.gpio_int1_debounce_reg_i(db), .gpio_int2_debounce_reg_i(db),
		.standby_irq_o(sb_irq), .gpio_int1_o(g1), .gpio_int2_o(g2),
		.wakeup_ctrl_wr_i(wr), .sleep_enable_bit_i(slp),
		.sleep_start_o(slps));
	initial forever #4 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (wrst === 1'h1) warm_cnt <= warm_cnt + 1;
		if (cyc == 5000) begin
			mismatches++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic cycles(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : cycles
	task automatic wait_gate(input logic [2:0] g);
		for (int i = 0; i < 40 && gate !== g; i++) cycles(1);
		chk(gate, g);
	endtask : wait_gate
	task automatic t_stage;
		@(posedge mclk_i);
		s1_i <= {1'h0, 1'h1, 4'h0, 6'h00, 8'h00, 6'h00};
		s2_i <= {1'h0, 1'h0, 4'h2, 6'h00, 8'h29, 6'h01};
		locked <= 1'h1;
		cycles(3);
		chk(s1_o, s1_i);
		chk(s2_o, s2_i);
		chk(st_o.pll_raw_lock, 1'h1);
	endtask : t_stage
	task automatic t_lockloss;
		@(posedge mclk_i);
		req <= clk_cfg_pkg::SRC_SYNTH;
		ld <= {1'h1, 2'h1, 16'h0004, 16'h0020, 32'h0, 16'h0003};
		wait_gate(3'h2);
		cycles(40);
		chk(warm_cnt, 0);
		@(posedge mclk_i);
		locked <= 1'h0;
		for (int i = 0; i < 60 && warm_cnt == 0; i++) cycles(1);
		cycles(2);
		chk(warm_cnt, 1);
		chk(st_o, 4'h7);
		chk(sel, clk_cfg_pkg::SRC_REFERENCE);
		@(posedge mclk_i);
		locked <= 1'h1;
		ld.lockloss_detect_enable <= 1'h0;
		cycles(20);
		chk(sel, clk_cfg_pkg::SRC_REFERENCE);
		chk(st_o, 4'hd);
		chk(useen, 1'h1);
		@(posedge mclk_i);
		lclr <= 1'h1;
		oclr <= 1'h1;
		srd <= 1'h1;
		@(posedge mclk_i);
		lclr <= 1'h0;
		oclr <= 1'h0;
		srd <= 1'h0;
		cycles(2);
		chk(st_o, 4'h8);
		chk(useen, 1'h0);
		wait_gate(3'h2);
		@(posedge mclk_i);
		req <= clk_cfg_pkg::SRC_ALTERNATE;
		wait_gate(3'h4);
		@(posedge mclk_i);
		req <= clk_cfg_pkg::SRC_REFERENCE;
		wait_gate(3'h1);
		@(posedge mclk_i);
		gc[31] <= 1'h1;
		ld.lockloss_detect_mode <= 2'h2;
		ld.ratio_max_threshold <= 16'h0008;
		ld.lockloss_detect_enable <= 1'h1;
		cycles(60);
		chk(warm_cnt, 1);
		chk(st_o, 4'he);
		@(posedge mclk_i);
		ld.lockloss_detect_enable <= 1'h0;
	endtask : t_lockloss
	task automatic t_ports;
		for (int k = 0; k < 4; k++) begin
			@(posedge mclk_i);
			gc[7:6] <= k[1:0];
			p1 <= k[0];
			cycles(2);
			chk(route, {k == 0, k == 2, k == 3, !k[0], k[0]});
		end
	endtask : t_ports
	task automatic t_gint;
		@(posedge mclk_i);
		gc[12:8] <= clk_cfg_pkg::GINT_SEL_ONE;
		gc[20:16] <= 5'h05;
		gpio[5] <= 1'h1;
		sby <= 1'h1;
		cycles(1);
		chk(sb_irq, 1'h0);
		cycles(8);
		chk({sb_irq, g1, g2}, 3'h7);
		@(posedge mclk_i);
		gc[12:8] <= clk_cfg_pkg::GINT_SEL_ZERO;
		gpio[5] <= 1'h0;
		sby <= 1'h0;
		cycles(9);
		chk({sb_irq, g1, g2}, 3'h0);
	endtask : t_gint
	task automatic t_sleep;
		@(posedge mclk_i);
		wr <= 1'h1;
		slp <= 1'h1;
		@(posedge mclk_i);
		wr <= 1'h0;
		#1 chk(slps, 1'h1);
		cycles(1);
		chk(slps, 1'h0);
	endtask : t_sleep
	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report
	initial begin
		cycles(6);
		chk({s1_o.stage_reset_bit, s1_o.stage_bypass_bit}, 2'h3);
		chk({sel, gate, route}, {2'h0, 3'h1, 5'h12});
		@(posedge mclk_i);
		rst_b_i <= 1'h1;
		t_stage();
		t_lockloss();
		t_ports();
		t_gint();
		t_sleep();
		final_report();
	end
endmodule : pll_lock_clock_config_tb
`default_nettype wire
